// [hdl/vrtcpb_pkg.sv]
// package: constants, states and carriers of the context packet builder
package vrtcpb_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_STRM_ID  = 8'h08;
  localparam logic [7:0] OFS_SWP_ID   = 8'h0C;
  localparam logic [7:0] OFS_SECONDS  = 8'h10;
  localparam logic [7:0] OFS_PS_HI    = 8'h14;
  localparam logic [7:0] OFS_PS_LO    = 8'h18;
  localparam logic [7:0] OFS_FREQ_HI  = 8'h1C;
  localparam logic [7:0] OFS_FREQ_LO  = 8'h20;
  localparam logic [7:0] OFS_BW_HI    = 8'h24;
  localparam logic [7:0] OFS_BW_LO    = 8'h28;
  localparam logic [7:0] OFS_REF_RAW  = 8'h2C;
  localparam logic [7:0] OFS_GAIN     = 8'h30;
  localparam logic [7:0] OFS_REF_WORD = 8'h34;

  // control register bits
  localparam int unsigned CTRL_SEND = 0;
  localparam int unsigned CTRL_CHG  = 1;
  localparam int unsigned CTRL_IQ   = 2;
  localparam int unsigned CTRL_STRT = 3;
  localparam int unsigned CTRL_SWP  = 4;

  // extension header fields
  localparam logic [3:0]  PKT_TYPE_EXT   = 4'h5;
  localparam logic [0:0]  CLASS_ID_FLAG  = 1'h0;
  localparam logic [1:0]  HDR_RESERVED   = 2'h0;
  localparam logic [0:0]  TS_MODE_BIT    = 1'h0;
  localparam logic [1:0]  INT_TS_UTC     = 2'h1;
  localparam logic [1:0]  FRAC_TS_PICO   = 2'h2;
  localparam logic [31:0] EXT_STREAM_ID  = 32'h9000_0004;
  localparam logic [15:0] BASE_WORDS     = 16'h0006;

  // indicator bit positions
  localparam int unsigned IND_CHG  = 31;
  localparam int unsigned IND_IQ   = 3;
  localparam int unsigned IND_STRT = 1;
  localparam int unsigned IND_SWP  = 0;

  // timebase
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam logic [63:0] PS_STEP       = 64'(CLK_PERIOD_NS * 1000);
  localparam logic [63:0] PS_PER_SEC    = 64'h0000_00E8_D4A5_1000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_HDR  = 9'h002,
    S_SID  = 9'h004,
    S_SEC  = 9'h008,
    S_PSH  = 9'h010,
    S_PSL  = 9'h020,
    S_IND  = 9'h040,
    S_STRT = 9'h080,
    S_SWP  = 9'h100
  } vrtcpb_fsm_t;

  typedef struct packed {
    logic [31:0] data;
    logic        last;
  } vrtcpb_word_t;

  typedef struct packed {
    vrtcpb_fsm_t fsm;
    vrtcpb_word_t out;
    logic [3:0]  seq;
    logic        chg;
    logic        iq;
    logic        st_en;
    logic        sw_en;
    logic [31:0] strm_id;
    logic [31:0] swp_id;
    logic [31:0] snap_sec;
    logic [63:0] snap_ps;
    logic [31:0] sec;
    logic [63:0] ps;
    logic [63:0] rd_ps;
    logic [63:0] freq;
    logic [63:0] bw;
    logic [15:0] ref_raw;
    logic [15:0] gain;
    logic [31:0] ref_word;
    logic [4:0]  ctrl;
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } vrtcpb_state_t;

endpackage

// [hdl/vrtcpb_top.sv]
// context packet builder: field encoders, timebase and extension packet framer
// Function
// - frequency offset is a 64-bit two's-complement hertz value, point after bit 20.
// - reference level word has its upper 16 bits forced to zero.
// - low 16 bits hold signed dBm, nine integer and seven fraction bits.
// - one step of the reference level equals 1/128 dBm.
// - reference level is corrected by the front end gain before sending.
// - extension header packet type is 0101.
// - class identifier flag is zero and no class words are sent.
// - the two reserved header bits are 00.
// - timestamp mode bit is 0, timestamps precise.
// - integer timestamp kind is 01, UTC seconds.
// - fractional timestamp kind is 10, real-time picoseconds.
// - 4-bit sequence starts at zero, steps per packet, wraps after 15.
// - size field counts every 32-bit word of the packet.
// - stream identifier word is 0x90000004.
// - seconds word holds UTC seconds since 1970.
// - picosecond count restarts whenever seconds advance.
// - order is header, stream id, seconds, two picosecond words, indicator, fields.
// - indicator bit 31 change, 3 channel swap, 1 stream start, 0 sweep start.
// - change and swap add no words; stream and sweep start add one each.
// - fields follow indicator bit order from the top bit down.
// - change flag set with changed fields, or clear for unchanged packets.
// - channel swap flag is 1 when converter channels are exchanged.
// - stream and sweep start fields are 32-bit unsigned identifiers.
// - bandwidth is 64-bit two's-complement hertz, same split as frequency offset.
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module vrtcpb_top (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output vrtcpb_pkg::vrtcpb_word_t   pkt_word,
  output logic                       pkt_valid,
  input  wire logic                  pkt_ready,
  output logic [63:0]                freq_offset_field,
  output logic [63:0]                bandwidth_field,
  output logic [31:0]                ref_level_field
);

  vrtcpb_pkg::vrtcpb_state_t r;
  vrtcpb_pkg::vrtcpb_state_t n;

  logic                      acc;
  logic                      wr_fire;
  logic                      rd_fire;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // word count follows the enabled optional fields
  function automatic logic [15:0] pkt_size(input vrtcpb_pkg::vrtcpb_state_t q);
    return vrtcpb_pkg::BASE_WORDS + {15'h0000, q.st_en} + {15'h0000, q.sw_en};
  endfunction

  function automatic vrtcpb_pkg::vrtcpb_fsm_t next_of(input vrtcpb_pkg::vrtcpb_fsm_t s,
                                                     input vrtcpb_pkg::vrtcpb_state_t q);
    vrtcpb_pkg::vrtcpb_fsm_t t;
    t = vrtcpb_pkg::S_IDLE;
    unique case (s)
      vrtcpb_pkg::S_HDR:  t = vrtcpb_pkg::S_SID;
      vrtcpb_pkg::S_SID:  t = vrtcpb_pkg::S_SEC;
      vrtcpb_pkg::S_SEC:  t = vrtcpb_pkg::S_PSH;
      vrtcpb_pkg::S_PSH:  t = vrtcpb_pkg::S_PSL;
      vrtcpb_pkg::S_PSL:  t = vrtcpb_pkg::S_IND;
      // fields in indicator bit order, top bit first
      vrtcpb_pkg::S_IND:  t = q.st_en ? vrtcpb_pkg::S_STRT :
                              (q.sw_en ? vrtcpb_pkg::S_SWP : vrtcpb_pkg::S_IDLE);
      vrtcpb_pkg::S_STRT: t = q.sw_en ? vrtcpb_pkg::S_SWP : vrtcpb_pkg::S_IDLE;
      vrtcpb_pkg::S_SWP:  t = vrtcpb_pkg::S_IDLE;
      vrtcpb_pkg::S_IDLE: t = vrtcpb_pkg::S_IDLE;
      default:            t = vrtcpb_pkg::S_IDLE;
    endcase
    return t;
  endfunction

  function automatic logic [31:0] word_of(input vrtcpb_pkg::vrtcpb_fsm_t s,
                                          input vrtcpb_pkg::vrtcpb_state_t q);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (s)
      vrtcpb_pkg::S_HDR: begin
        w = {vrtcpb_pkg::PKT_TYPE_EXT,
             vrtcpb_pkg::CLASS_ID_FLAG,
             vrtcpb_pkg::HDR_RESERVED,
             vrtcpb_pkg::TS_MODE_BIT,
             vrtcpb_pkg::INT_TS_UTC,
             vrtcpb_pkg::FRAC_TS_PICO,
             q.seq, pkt_size(q)};
      end
      vrtcpb_pkg::S_SID:  w = vrtcpb_pkg::EXT_STREAM_ID;
      vrtcpb_pkg::S_SEC:  w = q.snap_sec;
      vrtcpb_pkg::S_PSH:  w = q.snap_ps[63:32];
      vrtcpb_pkg::S_PSL:  w = q.snap_ps[31:0];
      vrtcpb_pkg::S_IND: begin
        w[vrtcpb_pkg::IND_CHG]  = q.chg;
        w[vrtcpb_pkg::IND_IQ]   = q.iq;
        w[vrtcpb_pkg::IND_STRT] = q.st_en;
        w[vrtcpb_pkg::IND_SWP]  = q.sw_en; // all other bits stay zero
      end
      vrtcpb_pkg::S_STRT: w = q.strm_id;
      vrtcpb_pkg::S_SWP:  w = q.swp_id;
      vrtcpb_pkg::S_IDLE: w = 32'h0000_0000;
      default:            w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  function automatic logic [31:0] read_of(input logic [7:0] a,
                                          input vrtcpb_pkg::vrtcpb_state_t q,
                                          output logic hit);
    logic [31:0] d;
    d = 32'h0000_0000;
    hit = 1'b1;
    unique case ({a[7:2], 2'b00})
      vrtcpb_pkg::OFS_CTRL:     d = {27'h000_0000, q.ctrl};
      vrtcpb_pkg::OFS_STATUS:   d = {24'h00_0000, q.seq, 3'h0, q.fsm != vrtcpb_pkg::S_IDLE};
      vrtcpb_pkg::OFS_STRM_ID:  d = q.strm_id;
      vrtcpb_pkg::OFS_SWP_ID:   d = q.swp_id;
      vrtcpb_pkg::OFS_SECONDS:  d = q.sec;
      vrtcpb_pkg::OFS_PS_HI:    d = q.rd_ps[63:32];
      vrtcpb_pkg::OFS_PS_LO:    d = q.rd_ps[31:0];
      vrtcpb_pkg::OFS_FREQ_HI:  d = q.freq[63:32];
      vrtcpb_pkg::OFS_FREQ_LO:  d = q.freq[31:0];
      vrtcpb_pkg::OFS_BW_HI:    d = q.bw[63:32];
      vrtcpb_pkg::OFS_BW_LO:    d = q.bw[31:0];
      vrtcpb_pkg::OFS_REF_RAW:  d = {16'h0000, q.ref_raw};
      vrtcpb_pkg::OFS_GAIN:     d = {16'h0000, q.gain};
      vrtcpb_pkg::OFS_REF_WORD: d = q.ref_word;
      default: begin
        hit = 1'b0;
      end
    endcase
    return d;
  endfunction

  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready  = !r.w_got && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign pkt_valid     = r.fsm != vrtcpb_pkg::S_IDLE;
  assign pkt_word      = r.out;
  assign acc           = pkt_valid && pkt_ready;
  assign wr_fire       = r.aw_got && r.w_got && !r.bvalid;
  assign rd_fire       = s_axi_arvalid && !r.rvalid;

  assign freq_offset_field = r.freq;
  assign bandwidth_field   = r.bw;
  assign ref_level_field   = r.ref_word;

  always_comb begin
    logic        hit;
    logic [31:0] rd;
    logic [63:0] ps_sum;
    hit    = 1'b0;
    rd     = 32'h0000_0000;
    n      = r;
    // free-running UTC timebase; picoseconds restart as seconds advance
    ps_sum = r.ps + vrtcpb_pkg::PS_STEP;
    if (ps_sum >= vrtcpb_pkg::PS_PER_SEC) begin
      n.ps  = ps_sum - vrtcpb_pkg::PS_PER_SEC;
      n.sec = r.sec + 32'h0000_0001;
    end else begin
      n.ps  = ps_sum;
    end
    n.ctrl[vrtcpb_pkg::CTRL_SEND] = 1'b0;
    // write channel, address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_fire) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = vrtcpb_pkg::RESP_OKAY;
      unique case ({r.awaddr[7:2], 2'b00})
        vrtcpb_pkg::OFS_CTRL:    n.ctrl = 5'(merge({27'h000_0000, r.ctrl}, r.wdata, r.wstrb));
        vrtcpb_pkg::OFS_STRM_ID: n.strm_id = merge(r.strm_id, r.wdata, r.wstrb);
        vrtcpb_pkg::OFS_SWP_ID:  n.swp_id = merge(r.swp_id, r.wdata, r.wstrb);
        vrtcpb_pkg::OFS_SECONDS: begin
          n.sec = merge(r.sec, r.wdata, r.wstrb);
          n.ps  = 64'h0000_0000_0000_0000;
        end
        vrtcpb_pkg::OFS_FREQ_HI: n.freq[63:32] = merge(r.freq[63:32], r.wdata, r.wstrb);
        vrtcpb_pkg::OFS_FREQ_LO: n.freq[31:0] = merge(r.freq[31:0], r.wdata, r.wstrb);
        vrtcpb_pkg::OFS_BW_HI:   n.bw[63:32] = merge(r.bw[63:32], r.wdata, r.wstrb);
        vrtcpb_pkg::OFS_BW_LO:   n.bw[31:0] = merge(r.bw[31:0], r.wdata, r.wstrb);
        vrtcpb_pkg::OFS_REF_RAW: n.ref_raw = 16'(merge({16'h0000, r.ref_raw}, r.wdata, r.wstrb));
        vrtcpb_pkg::OFS_GAIN:    n.gain = 16'(merge({16'h0000, r.gain}, r.wdata, r.wstrb));
        vrtcpb_pkg::OFS_STATUS, vrtcpb_pkg::OFS_PS_HI, vrtcpb_pkg::OFS_PS_LO,
        vrtcpb_pkg::OFS_REF_WORD: begin
          n.bresp = vrtcpb_pkg::RESP_OKAY;
        end
        default: begin
          n.bresp = vrtcpb_pkg::RESP_SLVERR;
        end
      endcase
    end
    // read channel; a seconds read latches the picoseconds for tear-free reads
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (rd_fire) begin
      rd      = read_of(s_axi_araddr, r, hit);
      n.rvalid = 1'b1;
      n.rdata  = rd;
      n.rresp  = hit ? vrtcpb_pkg::RESP_OKAY : vrtcpb_pkg::RESP_SLVERR;
      if ({s_axi_araddr[7:2], 2'b00} == vrtcpb_pkg::OFS_SECONDS) begin
        n.rd_ps = r.ps;
      end
    end
    // gain-corrected level in 1/128 dBm steps, upper half zero
    n.ref_word = {16'h0000, n.ref_raw - n.gain};
    // framer; a send request while busy is ignored
    if (r.fsm == vrtcpb_pkg::S_IDLE) begin
      if (r.ctrl[vrtcpb_pkg::CTRL_SEND]) begin
        n.fsm      = vrtcpb_pkg::S_HDR;
        n.chg      = r.ctrl[vrtcpb_pkg::CTRL_CHG];
        n.iq       = r.ctrl[vrtcpb_pkg::CTRL_IQ];
        n.st_en    = r.ctrl[vrtcpb_pkg::CTRL_STRT];
        n.sw_en    = r.ctrl[vrtcpb_pkg::CTRL_SWP];
        n.snap_sec = r.sec;
        n.snap_ps  = r.ps;
      end
    end else if (acc) begin
      n.fsm = next_of(r.fsm, r);
      if (r.out.last) begin
        n.seq = r.seq + 4'h1;
      end
    end
    // a held word stands even if a field register is rewritten meanwhile
    if (acc || r.fsm == vrtcpb_pkg::S_IDLE) begin
      n.out.data = word_of(n.fsm, n);
      n.out.last = (n.fsm != vrtcpb_pkg::S_IDLE) && (next_of(n.fsm, n) == vrtcpb_pkg::S_IDLE);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r     <= '0;
      r.fsm <= vrtcpb_pkg::S_IDLE;
    end else begin
      r <= n;
    end
  end

  // helpers for checks: words in the current packet and captured size
  logic [15:0] chk_cnt;
  logic [15:0] chk_size;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chk_cnt  <= 16'h0000;
      chk_size <= 16'h0000;
    end else if (acc) begin
      chk_cnt <= r.out.last ? 16'h0000 : chk_cnt + 16'h0001;
      if (r.fsm == vrtcpb_pkg::S_HDR) begin
        chk_size <= r.out.data[15:0];
      end
    end
  end

  sequence hdr_taken;
    acc && r.fsm == vrtcpb_pkg::S_HDR;
  endsequence

  sequence fixed_words;
    r.fsm == vrtcpb_pkg::S_SID ##1 (r.fsm == vrtcpb_pkg::S_SID || r.fsm == vrtcpb_pkg::S_SEC);
  endsequence

  a_hdr_fixed: assert property (@(posedge clk) disable iff (sys_rst)
    pkt_valid && r.fsm == vrtcpb_pkg::S_HDR |-> r.out.data[31:20] == 12'h506)
    else $error("extension header fixed bits wrong");

  a_seq_step: assert property (@(posedge clk) disable iff (sys_rst)
    acc && r.out.last |=> r.seq == 4'($past(r.seq) + 4'h1))
    else $error("sequence count did not step by one");

  a_size_match: assert property (@(posedge clk) disable iff (sys_rst)
    acc && r.out.last && r.fsm != vrtcpb_pkg::S_HDR |-> chk_cnt + 16'h0001 == chk_size)
    else $error("packet word count differs from size field");

  a_sid_word: assert property (@(posedge clk) disable iff (sys_rst)
    pkt_valid && r.fsm == vrtcpb_pkg::S_SID |-> r.out.data == 32'h9000_0004)
    else $error("stream identifier word wrong");

  a_word_order: assert property (@(posedge clk) disable iff (sys_rst)
    hdr_taken |=> fixed_words)
    else $error("header not followed by stream identifier");

  a_ind_spare: assert property (@(posedge clk) disable iff (sys_rst)
    pkt_valid && r.fsm == vrtcpb_pkg::S_IND |-> r.out.data[30:4] == 27'h000_0000
      && !r.out.data[2] && r.out.data[1] == r.st_en && r.out.data[0] == r.sw_en)
    else $error("indicator word spare bits set");

  a_field_order: assert property (@(posedge clk) disable iff (sys_rst)
    acc && r.fsm == vrtcpb_pkg::S_IND && r.st_en |=> r.fsm == vrtcpb_pkg::S_STRT
      ##0 r.out.data == r.strm_id)
    else $error("stream start field out of order");

  a_ps_restart: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(r.sec) |-> r.ps < vrtcpb_pkg::PS_STEP)
    else $error("picoseconds did not restart with seconds");

  a_ref_corr: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 ref_level_field == {16'h0000, 16'($past(n.ref_raw) - $past(n.gain))})
    else $error("reference level not gain corrected");

  sequence sweep_word;
    r.fsm == vrtcpb_pkg::S_SWP ##0 r.out.data == r.swp_id;
  endsequence

  a_hdr_size: assert property (@(posedge clk) disable iff (sys_rst)
    pkt_valid && r.fsm == vrtcpb_pkg::S_HDR |-> r.out.data[15:0] == 16'h0006
      + {15'h0000, r.st_en} + {15'h0000, r.sw_en})
    else $error("header size field wrong");

  a_hdr_count: assert property (@(posedge clk) disable iff (sys_rst)
    pkt_valid && r.fsm == vrtcpb_pkg::S_HDR |-> r.out.data[19:16] == r.seq)
    else $error("header sequence count wrong");

  a_ind_flags: assert property (@(posedge clk) disable iff (sys_rst)
    pkt_valid && r.fsm == vrtcpb_pkg::S_IND |-> r.out.data[31] == r.chg
      && r.out.data[3] == r.iq)
    else $error("indicator change or swap flag wrong");

  a_sweep_field: assert property (@(posedge clk) disable iff (sys_rst)
    acc && r.fsm == vrtcpb_pkg::S_STRT && r.sw_en |=> sweep_word)
    else $error("sweep start field out of order");

  a_word_hold: assert property (@(posedge clk) disable iff (sys_rst)
    pkt_valid && !pkt_ready |=> pkt_valid && $stable(r.out))
    else $error("packet word changed before it was taken");

  a_last_idle: assert property (@(posedge clk) disable iff (sys_rst)
    acc && r.out.last |=> !pkt_valid)
    else $error("packet did not end after its last word");

  a_seq_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    acc && r.out.last && r.seq == 4'hF |=> r.seq == 4'h0)
    else $error("sequence count did not wrap to zero");

endmodule
`default_nettype wire

// [test/vrtcpb_host_model.sv]
// host receiver model: takes packet words, walks the indicator, counts packets
`timescale 1ns/100ps
`default_nettype none
module vrtcpb_host_model (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire vrtcpb_pkg::vrtcpb_word_t pkt_word,
  input  wire logic                pkt_valid,
  input  wire logic                stall,
  output logic                     pkt_ready,
  output logic [31:0]              words [8],
  output logic [7:0]               n_pkts,
  output logic [7:0]               n_err
);
  logic [3:0]  idx_r;
  logic [15:0] size_r;
  wire         take = pkt_valid && pkt_ready;
  wire  [15:0] size_now = (idx_r == 4'h0) ? pkt_word.data[15:0] : size_r;
  wire         last_exp = ({12'h000, idx_r} + 16'h0001) == size_now;
  wire  [15:0] size_ind = 16'h0006 + {15'h0, pkt_word.data[1]} + {15'h0, pkt_word.data[0]};
  wire         bad = (pkt_word.last !== last_exp) || (idx_r == 4'h5 && size_r !== size_ind);

  always_ff @(posedge clk) begin
    if (take) begin
      words[idx_r[2:0]] <= pkt_word.data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pkt_ready <= 1'b0;
      idx_r     <= 4'h0;
      size_r    <= 16'h0000;
      n_pkts    <= 8'h00;
      n_err     <= 8'h00;
    end else begin
      pkt_ready <= stall ? !pkt_ready : 1'b1;
      if (take) begin
        idx_r <= pkt_word.last ? 4'h0 : idx_r + 4'h1;
        if (idx_r == 4'h0) begin
          size_r <= pkt_word.data[15:0];
        end
        // size checked against the indicator walk and the last flag
        if (bad) begin
          n_err <= n_err + 8'h01;
        end
        if (pkt_word.last) begin
          n_pkts <= n_pkts + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [test/vrtcpb_top_test.sv]
// self-checking testbench of the context packet builder
`timescale 1ns/100ps
`default_nettype none
module vrtcpb_top_test;
  typedef struct packed {
    logic chg; logic iq; logic st; logic sw; logic [31:0] sid; logic [31:0] wid;
  } vrtcpb_row_t;
  logic        clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, stall;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, sec;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, pkt_valid, pkt_ready;
  logic [1:0]  bresp, rresp, rsp;
  vrtcpb_pkg::vrtcpb_word_t pkt_word;
  logic [63:0] freq_f, bw_f;
  logic [31:0] ref_f;
  logic [31:0] words [8];
  logic [7:0]  n_pkts, n_err, npk;
  int          n_fail = 0;
  int          checks_done = 0;
  int          i;
  vrtcpb_row_t rows [4] = '{'{1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_0011, 32'h0000_0022},
                            '{1'b1, 1'b1, 1'b1, 1'b1, 32'hFFFF_FFFF, 32'h8000_0001},
                            '{1'b1, 1'b0, 1'b1, 1'b0, 32'h1234_5678, 32'h0000_0000},
                            '{1'b0, 1'b1, 1'b0, 1'b1, 32'h0000_0000, 32'hA5A5_0F0F}};
  logic [47:0] refs [3] = '{48'h0080_0000_0080, 48'h0080_0100_FF80, 48'h0001_0002_FFFF};

  vrtcpb_top dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pkt_word(pkt_word), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .freq_offset_field(freq_f), .bandwidth_field(bw_f), .ref_level_field(ref_f));
  vrtcpb_host_model host (.clk(clk), .sys_rst(sys_rst), .pkt_word(pkt_word),
    .pkt_valid(pkt_valid), .stall(stall), .pkt_ready(pkt_ready), .words(words),
    .n_pkts(n_pkts), .n_err(n_err));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    n_fail++;
    $display("[FAIL] %0t wait ran out", $time);
    end_sim();
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    int   n;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    hb = 1'b0;
    for (n = 0; n < 50 && !hb; n++) begin
      @(negedge clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      r  = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    if (!hb) hang();
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    int   n;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    hr = 1'b0;
    for (n = 0; n < 50 && !hr; n++) begin
      @(negedge clk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      d  = rdata;
      r  = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
    end
    if (!hr) hang();
    rready <= 1'b0;
  endtask

  task automatic wait_pk(input logic [7:0] target);
    int n;
    for (n = 0; n < 300 && n_pkts != target; n++) @(posedge clk);
    if (n_pkts != target) hang();
  endtask

  task automatic send(input vrtcpb_row_t w, input logic [31:0] s);
    axw(vrtcpb_pkg::OFS_STRM_ID, w.sid, rsp);
    axw(vrtcpb_pkg::OFS_SWP_ID, w.wid, rsp);
    axw(vrtcpb_pkg::OFS_SECONDS, s, rsp);
    npk = n_pkts;
    axw(vrtcpb_pkg::OFS_CTRL, {27'h0, w.sw, w.st, w.iq, w.chg, 1'b1}, rsp);
    wait_pk(npk + 8'h01);
  endtask

  task automatic chk_pkt(input vrtcpb_row_t w, input logic [3:0] seq, input logic [31:0] s);
    int k;
    chk(words[0], {4'b0101, 1'b0, 2'b00, 1'b0, 2'b01, 2'b10, seq, 16'(6 + w.st + w.sw)});
    chk(words[1], 32'h9000_0004);
    chk(words[2], s);
    chk(words[3], 32'h0);
    chk(words[4] % 5000 == 0 && words[4] < 32'd500000, 1);
    chk(words[5], {w.chg, 27'h0, w.iq, 1'b0, w.st, w.sw});
    k = 6;
    if (w.st) begin
      chk(words[k], w.sid);
      k = 7;
    end
    if (w.sw) chk(words[k], w.wid);
  endtask

  initial begin
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, stall} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata  = 32'h0;
    wstrb  = 4'hF;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    chk(pkt_valid, 0);
    chk(ref_f, 0);
    axr(vrtcpb_pkg::OFS_STATUS, rd, rsp);
    chk(rd[7:0], 8'h00);
    $display("reset test done");
    for (i = 0; i < 17; i++) begin
      sec = 32'h5E00_0000 + i;
      send(rows[i % 4], sec);
      chk_pkt(rows[i % 4], i[3:0], sec);
    end
    $display("packet rows done");
    axw(vrtcpb_pkg::OFS_FREQ_HI, 32'hFFFF_FFFE, rsp);
    axw(vrtcpb_pkg::OFS_FREQ_LO, 32'h8010_0000, rsp);
    axw(vrtcpb_pkg::OFS_BW_HI, 32'h0000_0004, rsp);
    axw(vrtcpb_pkg::OFS_BW_LO, 32'hC350_0000, rsp);
    chk(freq_f, 64'hFFFF_FFFE_8010_0000);
    chk(bw_f, 64'h0000_0004_C350_0000);
    for (i = 0; i < 3; i++) begin
      axw(vrtcpb_pkg::OFS_REF_RAW, {16'h0, refs[i][47:32]}, rsp);
      axw(vrtcpb_pkg::OFS_GAIN, {16'h0, refs[i][31:16]}, rsp);
      @(posedge clk);
      chk(ref_f, {16'h0, refs[i][15:0]});
    end
    $display("field test done");
    axw(8'h3C, 32'h1234_5678, rsp);
    chk(rsp, vrtcpb_pkg::RESP_SLVERR);
    axr(8'h3C, rd, rsp);
    chk({rsp, rd}, {vrtcpb_pkg::RESP_SLVERR, 32'h0});
    axw(vrtcpb_pkg::OFS_SECONDS, 32'h0000_0100, rsp);
    axr(vrtcpb_pkg::OFS_SECONDS, rd, rsp);
    chk(rd, 32'h0000_0100);
    axr(vrtcpb_pkg::OFS_PS_HI, rd, rsp);
    chk(rd, 32'h0);
    axr(vrtcpb_pkg::OFS_PS_LO, rd, rsp);
    chk(rd % 5000 == 0 && rd != 0 && rd < 32'd200000, 1);
    $display("register test done");
    stall <= 1'b1;
    npk = n_pkts;
    axw(vrtcpb_pkg::OFS_CTRL, 32'h0000_001F, rsp);
    axw(vrtcpb_pkg::OFS_CTRL, 32'h0000_001F, rsp);
    stall <= 1'b0;
    wait_pk(npk + 8'h01);
    repeat (40) @(posedge clk);
    chk(n_pkts, npk + 8'h01);
    $display("busy test done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    sec = 32'h0000_0ABC;
    send(rows[2], sec);
    chk_pkt(rows[2], 4'h0, sec);
    chk(n_err, 0);
    $display("second reset test done");
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge clk);
    hang();
  end
endmodule
`default_nettype wire
